// [include/udp_packer_pkg.sv]
package udp_packer_pkg;
  // Timing
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          MS_NS          = 1000000;
  localparam int          MS_CYCLES      = MS_NS / CLK_PERIOD_NS;

  // Sizes
  localparam int          BUF_BYTES      = 1024;
  localparam int          BUF_AW         = 10;
  localparam int          CNT_W          = 11;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          NUM_RANGES     = 4;
  localparam logic [10:0] BUF_FULL_CNT   = 11'h400;
  localparam logic [10:0] PACK_LEN_MAX   = 11'h400;

  // Register byte addresses
  localparam logic [7:0]  ADDR_PACK      = 8'h00;
  localparam logic [7:0]  ADDR_DELIM     = 8'h04;
  localparam logic [7:0]  ADDR_FORCE     = 8'h08;
  localparam logic [7:0]  ADDR_LISTEN    = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;
  localparam logic [7:0]  ADDR_RANGE0    = 8'h20;
  localparam logic [7:0]  RANGE_STRIDE   = 8'h10;
  localparam logic [7:0]  RANGE_END_OFS  = 8'h04;
  localparam logic [7:0]  RANGE_PORT_OFS = 8'h08;

  // Fields
  localparam int          PACK_LEN_LSB   = 0;
  localparam int          PACK_LEN_MSB   = 10;
  localparam int          PROC_LSB       = 12;
  localparam int          PROC_MSB       = 13;
  localparam int          D1_LSB         = 0;
  localparam int          D1_MSB         = 7;
  localparam int          D2_LSB         = 8;
  localparam int          D2_MSB         = 15;
  localparam int          D1_EN_BIT      = 16;
  localparam int          D2_EN_BIT      = 17;
  localparam int          HALF_MSB       = 15;

  // Reset values
  localparam logic [15:0] PORT_DEFAULT   = 16'h0fa1;
  localparam logic [10:0] PACK_LEN_RST   = 11'h000;
  localparam logic [15:0] FORCE_RST      = 16'h0000;

  typedef enum logic [1:0] {
    PROC_NOTHING,
    PROC_PLUS1,
    PROC_PLUS2,
    PROC_STRIP
  } proc_mode_t;

  typedef enum logic [2:0] {
    ST_COLLECT,
    ST_DEST,
    ST_FETCH,
    ST_LOAD,
    ST_SEND
  } pack_state_t;
endpackage

// [tb/net_sink_model.sv]
`timescale 1ns/1ps
module net_sink_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        valid_i,
  input  wire logic        last_i,
  input  wire logic [31:0] ip_i,
  input  wire logic [15:0] port_i,
  input  wire logic        slow_i,
  output logic             ready_o
);
  logic [1:0]  pace_ff;
  logic [7:0]  data_q[$];
  logic [47:0] dest_q[$];

  // Slow mode takes one beat in four
  assign ready_o = !slow_i || (pace_ff == 2'h0);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pace_ff <= 2'h0;
    end else begin
      pace_ff <= pace_ff + 2'h1;
      if (valid_i && ready_o) begin
        data_q.push_back(data_i);
        if (last_i) begin
          dest_q.push_back({port_i, ip_i});
        end
      end
    end
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import udp_packer_pkg::*;
  localparam logic [31:0] IP_A = 32'h0a00_0001;
  localparam logic [31:0] IP_B = 32'h0a00_0002;
  localparam logic [15:0] DST  = 16'h1234;

  logic        CLK_I = 1'b0;
  logic        RESET_N_I = 1'b0;
  logic [7:0]  REG_ADDR_I = 8'h00;
  logic [31:0] REG_WDATA_I = 32'h0;
  logic        REG_WR_I = 1'b0;
  logic        REG_RD_I = 1'b0;
  logic [31:0] REG_RDATA_O;
  logic [7:0]  RX_DATA_I = 8'h00;
  logic        RX_VALID_I = 1'b0;
  logic        RX_READY_O, TX_VALID_O, TX_READY_I, TX_LAST_O;
  logic [7:0]  TX_DATA_O;
  logic [31:0] TX_DEST_IP_O;
  logic [15:0] TX_DEST_PORT_O, LISTEN_PORT_O;
  logic        slow = 1'b0;
  int          err_count = 0;
  int          checks_done = 0;
  logic [7:0]  fr[$];

  always #20 CLK_I = ~CLK_I;

  serial_udp_packer #(.MS_CYC(10)) serial_udp_packer_i (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .RX_DATA_I(RX_DATA_I),
    .RX_VALID_I(RX_VALID_I), .RX_READY_O(RX_READY_O), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O),
    .TX_READY_I(TX_READY_I), .TX_LAST_O(TX_LAST_O), .TX_DEST_IP_O(TX_DEST_IP_O),
    .TX_DEST_PORT_O(TX_DEST_PORT_O), .LISTEN_PORT_O(LISTEN_PORT_O));

  net_sink_model net_sink_model_i (
    .clk_i(CLK_I), .reset_n_i(RESET_N_I), .data_i(TX_DATA_O), .valid_i(TX_VALID_O),
    .last_i(TX_LAST_O), .ip_i(TX_DEST_IP_O), .port_i(TX_DEST_PORT_O), .slow_i(slow),
    .ready_o(TX_READY_I));

  ////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    @(negedge CLK_I);
    cmp("read data", 48'(exp), 48'(REG_RDATA_O));
    @(posedge CLK_I);
  endtask

  task automatic put(input logic [7:0] b);
    int n;
    RX_DATA_I <= b;
    RX_VALID_I <= 1'b1;
    for (n = 0; n < 40000; n++) begin
      @(negedge CLK_I);
      if (RX_READY_O === 1'b1) break;
    end
    @(posedge CLK_I);
    RX_VALID_I <= 1'b0;
    RX_DATA_I <= ~b;
    @(posedge CLK_I);
    if (n == 40000) begin
      cmp("rx ready", 48'h1, 48'h0);
      final_report();
    end
  endtask

  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) put(q[i]);
  endtask

  // One frame, one copy per address of range 0
  task automatic expect_frame(input logic [7:0] q[$]);
    int n;
    for (n = 0; n < 40000 && net_sink_model_i.dest_q.size() < 2; n++) @(posedge CLK_I);
    if (n == 40000) begin
      cmp("frame wait", 48'h1, 48'h0);
      final_report();
    end
    cmp("dest a", {DST, IP_A}, net_sink_model_i.dest_q.pop_front());
    cmp("dest b", {DST, IP_B}, net_sink_model_i.dest_q.pop_front());
    for (n = 0; n < 2 * q.size(); n++) begin
      cmp("frame byte", 48'(q[n % q.size()]), 48'(net_sink_model_i.data_q.pop_front()));
    end
    // Let the range walk finish so the sender is idle again
    repeat (8) @(posedge CLK_I);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_LISTEN, 32'h0000_0fa1);
    rd(ADDR_RANGE0 + RANGE_PORT_OFS, 32'h0000_0fa1);
    rd(8'hfc, 32'h0);
    wr(ADDR_LISTEN, 32'h0);
    rd(ADDR_LISTEN, 32'h0000_0fa1);
    wr(ADDR_LISTEN, 32'h0000_ffff);
    cmp("listen port", 48'hffff, 48'(LISTEN_PORT_O));
    wr(ADDR_PACK, 32'h0000_07ff);
    rd(ADDR_PACK, 32'h0000_0400);
    wr(ADDR_RANGE0, IP_A);
    wr(ADDR_RANGE0 + RANGE_END_OFS, IP_B);
    wr(ADDR_RANGE0 + RANGE_PORT_OFS, 32'(DST));
    $display("test registers done");
  endtask

  task automatic t_pack();
    wr(ADDR_PACK, 32'h0000_0003);
    wr(ADDR_DELIM, 32'h0001_000d);
    fr = '{8'h0d, 8'h41, 8'h42};
    send(fr);
    expect_frame(fr);
    rd(ADDR_STATUS, 32'h0);
    $display("test packing length done");
  endtask

  task automatic t_delim();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PACK, 32'(m) << PROC_LSB);
      fr = '{8'h11, 8'h22, 8'h0d};
      if (m == 1 || m == 2) fr.push_back(8'h33);
      if (m == 2) fr.push_back(8'h44);
      send(fr);
      if (m == 3) fr = '{8'h11, 8'h22};
      expect_frame(fr);
    end
    $display("test delimiter modes done");
  endtask

  task automatic t_both();
    wr(ADDR_DELIM, 32'h0003_0a0d);
    wr(ADDR_PACK, 32'h0);
    fr = '{8'h55, 8'h0d, 8'h66, 8'h0d, 8'h0a};
    send(fr);
    expect_frame(fr);
    $display("test two delimiters done");
  endtask

  // Fills buffer, then overfills the input fifo while a slow sink drains
  task automatic t_full();
    wr(ADDR_DELIM, 32'h0);
    wr(ADDR_FORCE, 32'h0000_0003);
    slow <= 1'b1;
    fr = {};
    for (int i = 0; i < 1024; i++) fr.push_back(i[7:0]);
    send(fr);
    for (int i = 0; i < 12; i++) put(8'ha0 + 8'(i));
    expect_frame(fr);
    fr = {};
    for (int i = 0; i < 12; i++) fr.push_back(8'ha0 + 8'(i));
    expect_frame(fr);
    slow <= 1'b0;
    $display("test full buffer done");
  endtask

  task automatic t_timer();
    fr = '{8'h71, 8'h72, 8'h73};
    foreach (fr[i]) begin
      put(fr[i]);
      repeat (12) @(posedge CLK_I);
    end
    rd(ADDR_STATUS, 32'h0000_0003);
    expect_frame(fr);
    $display("test force timer done");
  endtask

  initial begin
    repeat (16) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLK_I);
    t_regs();
    t_pack();
    t_delim();
    t_both();
    t_full();
    t_timer();
    cmp("sink leftover", 48'h0, 48'(net_sink_model_i.data_q.size()));
    final_report();
  end
endmodule

bind serial_udp_packer udp_packer_monitor udp_packer_monitor_i (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I), .TX_LAST_O(TX_LAST_O),
  .TX_DEST_IP_O(TX_DEST_IP_O), .TX_DEST_PORT_O(TX_DEST_PORT_O), .LISTEN_PORT_O(LISTEN_PORT_O));

// [tb/udp_packer_monitor.sv]
`timescale 1ns/1ps
module udp_packer_monitor (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        REG_RD_I,
  input  wire logic [31:0] REG_RDATA_O,
  input  wire logic [7:0]  TX_DATA_O,
  input  wire logic        TX_VALID_O,
  input  wire logic        TX_READY_I,
  input  wire logic        TX_LAST_O,
  input  wire logic [31:0] TX_DEST_IP_O,
  input  wire logic [15:0] TX_DEST_PORT_O,
  input  wire logic [15:0] LISTEN_PORT_O
);
  logic [10:0] beat_cnt_ff;

  default clocking mon_cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // Beats accepted so far in the current copy
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      beat_cnt_ff <= 11'h000;
    end else if (TX_VALID_O && TX_READY_I) begin
      beat_cnt_ff <= TX_LAST_O ? 11'h000 : beat_cnt_ff + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("read data seen outside read slot");
  listen_nonzero_a: assert property (LISTEN_PORT_O != 16'h0000)
    else $error("listen port is zero");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O))
    else $error("offered byte changed before acceptance");
  tx_gap_a: assert property (TX_VALID_O && TX_READY_I |=> !TX_VALID_O [*2])
    else $error("next byte offered too early");
  last_gap_a: assert property (TX_VALID_O && TX_READY_I && TX_LAST_O |=> !TX_VALID_O [*3])
    else $error("next copy offered too early");
  dest_set_a: assert property (TX_VALID_O |-> TX_DEST_IP_O != 32'h0)
    else $error("byte sent to empty destination");
  frame_len_a: assert property (TX_VALID_O |-> beat_cnt_ff < 11'h400)
    else $error("frame longer than buffer");
  dest_copy_a: assert property (TX_VALID_O && TX_READY_I && !TX_LAST_O |=>
    ($stable(TX_DEST_IP_O) && $stable(TX_DEST_PORT_O)) [*3])
    else $error("destination changed within a copy");
endmodule

// [verilog/byte_fifo.sv]
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW:0]      wr_ptr_ff;
  logic [PW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;
  logic             empty;
  logic             full;

  assign empty       = (wr_ptr_ff == rd_ptr_ff);
  assign full        = (wr_ptr_ff[PW] != rd_ptr_ff[PW]) && (wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;
  assign out_data_o  = mem_ff[rd_ptr_ff[PW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// [verilog/frame_buffer.sv]
`timescale 1ns/1ps
module frame_buffer #(
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [7:0]    rd_data_o
);
  logic [7:0] mem_ff [2**AW];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_ff[rd_addr_i];
  end
endmodule

// [verilog/serial_udp_packer.sv]
`timescale 1ns/1ps
module serial_udp_packer
  import udp_packer_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_VALID_I,
  output logic             RX_READY_O,
  output logic      [7:0]  TX_DATA_O,
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  output logic             TX_LAST_O,
  output logic      [31:0] TX_DEST_IP_O,
  output logic      [15:0] TX_DEST_PORT_O,
  output logic      [15:0] LISTEN_PORT_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic [10:0]       pack_len_ff;
  proc_mode_t        proc_ff;
  logic [7:0]        delim1_ff;
  logic [7:0]        delim2_ff;
  logic              d1_en_ff;
  logic              d2_en_ff;
  logic [15:0]       force_ms_ff;
  logic [15:0]       listen_ff;
  logic [31:0]       rng_begin_ff [NUM_RANGES];
  logic [31:0]       rng_end_ff   [NUM_RANGES];
  logic [15:0]       rng_port_ff  [NUM_RANGES];
  logic [31:0]       nxt_rdata;

  pack_state_t       state_ff;
  logic [CNT_W-1:0]  count_ff;
  logic [CNT_W-1:0]  frame_len_ff;
  logic [BUF_AW-1:0] idx_ff;
  logic [1:0]        wait_ff;
  logic              prev_d1_ff;
  logic [15:0]       idle_ms_ff;
  logic [15:0]       ms_div_ff;
  logic              ms_tick;
  logic [1:0]        rng_ff;
  logic [31:0]       ip_ff;

  logic [7:0]        f_data;
  logic              f_valid;
  logic              take;
  logic [CNT_W-1:0]  new_cnt;
  logic              hit;
  logic              release_now;
  logic [CNT_W-1:0]  rel_len;
  logic              timer_rel;
  logic [7:0]        mem_rd_data;

  function automatic logic [31:0] range_last(input logic [31:0] b, input logic [31:0] e);
    range_last = (e < b) ? b : e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pack_len_ff <= PACK_LEN_RST;
      proc_ff     <= PROC_NOTHING;
      delim1_ff   <= 8'h00;
      delim2_ff   <= 8'h00;
      d1_en_ff    <= 1'b0;
      d2_en_ff    <= 1'b0;
      force_ms_ff <= FORCE_RST;
      listen_ff   <= PORT_DEFAULT;
    end else if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        ADDR_PACK: begin
          // Values above 1024 saturate
          pack_len_ff <= (REG_WDATA_I[PACK_LEN_MSB:PACK_LEN_LSB] > PACK_LEN_MAX) ? PACK_LEN_MAX :
                         REG_WDATA_I[PACK_LEN_MSB:PACK_LEN_LSB];
          proc_ff     <= proc_mode_t'(REG_WDATA_I[PROC_MSB:PROC_LSB]);
        end
        ADDR_DELIM: begin
          delim1_ff <= REG_WDATA_I[D1_MSB:D1_LSB];
          delim2_ff <= REG_WDATA_I[D2_MSB:D2_LSB];
          d1_en_ff  <= REG_WDATA_I[D1_EN_BIT];
          d2_en_ff  <= REG_WDATA_I[D2_EN_BIT];
        end
        ADDR_FORCE: force_ms_ff <= REG_WDATA_I[HALF_MSB:0];
        ADDR_LISTEN: begin
          // Port zero is not legal and is refused
          if (REG_WDATA_I[HALF_MSB:0] != 16'h0000) begin
            listen_ff <= REG_WDATA_I[HALF_MSB:0];
          end
        end
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_RANGES; g++) begin : g_rng
      localparam logic [7:0] BASE = ADDR_RANGE0 + RANGE_STRIDE * 8'(g);
      always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          rng_begin_ff[g] <= 32'h0000_0000;
          rng_end_ff[g]   <= 32'h0000_0000;
          rng_port_ff[g]  <= PORT_DEFAULT;
        end else if (REG_WR_I) begin
          if (REG_ADDR_I == BASE) begin
            rng_begin_ff[g] <= REG_WDATA_I;
          end
          if (REG_ADDR_I == BASE + RANGE_END_OFS) begin
            rng_end_ff[g] <= REG_WDATA_I;
          end
          if (REG_ADDR_I == BASE + RANGE_PORT_OFS) begin
            rng_port_ff[g] <= REG_WDATA_I[HALF_MSB:0];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (REG_ADDR_I)
      ADDR_PACK:   nxt_rdata = {18'h0_0000, proc_ff, 1'b0, pack_len_ff};
      ADDR_DELIM:  nxt_rdata = {14'h0000, d2_en_ff, d1_en_ff, delim2_ff, delim1_ff};
      ADDR_FORCE:  nxt_rdata = {16'h0000, force_ms_ff};
      ADDR_LISTEN: nxt_rdata = {16'h0000, listen_ff};
      ADDR_STATUS: nxt_rdata = {13'h0000, (state_ff != ST_COLLECT), 7'h00, count_ff};
      default: begin
        for (int i = 0; i < NUM_RANGES; i++) begin
          if (REG_ADDR_I == ADDR_RANGE0 + RANGE_STRIDE * 8'(i)) begin
            nxt_rdata = rng_begin_ff[i];
          end
          if (REG_ADDR_I == ADDR_RANGE0 + RANGE_STRIDE * 8'(i) + RANGE_END_OFS) begin
            nxt_rdata = rng_end_ff[i];
          end
          if (REG_ADDR_I == ADDR_RANGE0 + RANGE_STRIDE * 8'(i) + RANGE_PORT_OFS) begin
            nxt_rdata = {16'h0000, rng_port_ff[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= nxt_rdata;
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
    end
  end

  assign LISTEN_PORT_O = listen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Input FIFO and 1 KB buffer
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (CLK_I),
    .reset_n_i   (RESET_N_I),
    .in_data_i   (RX_DATA_I),
    .in_valid_i  (RX_VALID_I),
    .in_ready_o  (RX_READY_O),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (take)
  );

  frame_buffer #(.AW(BUF_AW)) u_buf (
    .clk_i     (CLK_I),
    .wr_en_i   (take),
    .wr_addr_i (count_ff[BUF_AW-1:0]),
    .wr_data_i (f_data),
    .rd_addr_i (idx_ff),
    .rd_data_o (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Release decision
  assign take    = (state_ff == ST_COLLECT) && f_valid;
  assign new_cnt = count_ff + 1'b1;

  always_comb begin
    hit         = 1'b0;
    release_now = 1'b0;
    rel_len     = new_cnt;
    if (pack_len_ff != PACK_LEN_RST) begin
      release_now = (new_cnt == pack_len_ff);
    end else if (wait_ff != 2'd0) begin
      release_now = (wait_ff == 2'd1);
    end else if (d1_en_ff) begin
      if (d2_en_ff) begin
        hit = prev_d1_ff && (f_data == delim2_ff);
      end else begin
        hit = (f_data == delim1_ff);
      end
      unique case (proc_ff)
        PROC_NOTHING: release_now = hit;
        PROC_STRIP: begin
          release_now = hit;
          rel_len     = new_cnt - (d2_en_ff ? CNT_W'(2) : CNT_W'(1));
        end
        PROC_PLUS1, PROC_PLUS2: release_now = 1'b0;
      endcase
    end
    if (new_cnt == BUF_FULL_CNT) begin
      release_now = 1'b1;
    end
  end

  assign timer_rel = (force_ms_ff != FORCE_RST) && (count_ff != '0) && (idle_ms_ff == force_ms_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base and idle timer
  assign ms_tick = (ms_div_ff == 16'(MS_CYC - 1));

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ms_div_ff <= 16'h0000;
    end else begin
      ms_div_ff <= ms_tick ? 16'h0000 : ms_div_ff + 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      idle_ms_ff <= 16'h0000;
    end else if (take || state_ff != ST_COLLECT || count_ff == '0) begin
      idle_ms_ff <= 16'h0000;
    end else if (ms_tick && idle_ms_ff != force_ms_ff) begin
      idle_ms_ff <= idle_ms_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Collect and send
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff     <= ST_COLLECT;
      count_ff     <= '0;
      frame_len_ff <= '0;
      idx_ff       <= '0;
      wait_ff      <= 2'd0;
      prev_d1_ff   <= 1'b0;
      rng_ff       <= 2'd0;
      ip_ff        <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        ST_COLLECT: begin
          if (take) begin
            prev_d1_ff <= (f_data == delim1_ff);
            if (release_now) begin
              frame_len_ff <= rel_len;
              count_ff     <= '0;
              wait_ff      <= 2'd0;
              prev_d1_ff   <= 1'b0;
              rng_ff       <= 2'd0;
              ip_ff        <= rng_begin_ff[0];
              state_ff     <= ST_DEST;
            end else begin
              count_ff <= new_cnt;
              if (wait_ff != 2'd0) begin
                wait_ff <= wait_ff - 2'd1;
              end else if (hit && proc_ff == PROC_PLUS1) begin
                wait_ff <= 2'd1;
              end else if (hit && proc_ff == PROC_PLUS2) begin
                wait_ff <= 2'd2;
              end
            end
          end else if (timer_rel) begin
            frame_len_ff <= count_ff;
            count_ff     <= '0;
            wait_ff      <= 2'd0;
            prev_d1_ff   <= 1'b0;
            rng_ff       <= 2'd0;
            ip_ff        <= rng_begin_ff[0];
            state_ff     <= ST_DEST;
          end
        end
        ST_DEST: begin
          idx_ff <= '0;
          if (frame_len_ff != '0 && rng_begin_ff[rng_ff] != 32'h0000_0000 &&
              ip_ff <= range_last(rng_begin_ff[rng_ff], rng_end_ff[rng_ff])) begin
            state_ff <= ST_FETCH;
          end else if (frame_len_ff == '0 || rng_ff == 2'(NUM_RANGES - 1)) begin
            state_ff <= ST_COLLECT;
          end else begin
            rng_ff <= rng_ff + 2'd1;
            ip_ff  <= rng_begin_ff[rng_ff + 2'd1];
          end
        end
        ST_FETCH: state_ff <= ST_LOAD;
        ST_LOAD:  state_ff <= ST_SEND;
        ST_SEND: begin
          if (TX_READY_I) begin
            if (TX_LAST_O) begin
              ip_ff    <= ip_ff + 32'h0000_0001;
              state_ff <= ST_DEST;
            end else begin
              idx_ff   <= idx_ff + 1'b1;
              state_ff <= ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TX_DATA_O      <= 8'h00;
      TX_DEST_IP_O   <= 32'h0000_0000;
      TX_DEST_PORT_O <= 16'h0000;
    end else if (state_ff == ST_LOAD) begin
      TX_DATA_O      <= mem_rd_data;
      TX_DEST_IP_O   <= ip_ff;
      TX_DEST_PORT_O <= rng_port_ff[rng_ff];
    end
  end

  assign TX_VALID_O = (state_ff == ST_SEND);
  assign TX_LAST_O  = TX_VALID_O && ({1'b0, idx_ff} == frame_len_ff - 1'b1);
endmodule
